// ---- pic_pkg.sv ----
// Behaviour
// [R1] The NMI and every peripheral request are candidates for delivery.
// [R2] One winner is chosen by level first, then by interrupt number.
// [R3] The winning level is presented to the CPU on a level output.
// [R4] The winning interrupt number is presented beside its level.
// [R5] In stop mode, NMI or any enabled pending request raises wake.
// [R6] A hold cancel request goes to the bus master for pending interrupts.
// [R7] Each source has an 8-bit level register, level in bits 4..0. Here the delayed request has none; its level is in delay register bits 12..8.
// [R8] Hold cancel register: control bit 7, level threshold in bits 4..0.
// [R9] External channels detect high, low, rising or falling; NMI has no choice.
// [R10] Sixteen external channels, as two identical sets of eight.
// [R11] Software raises and withdraws the delayed request by register writes.
// [R12] Smaller level wins, then smaller number; all-ones level means disabled. Here the NMI (level 0x0f) wins over every level.
// [R13] Edge requests stay pending until cleared; level requests follow input.
package pic_pkg;
   localparam int NUM_SRC = 47;
   localparam int NUM_CAND = 48;
   localparam int EXT_CH = 16;
   localparam int EXT_SET_CH = 8;
   localparam logic [4:0] LVL_OFF = 5'h1f;
   localparam logic [4:0] NMI_LEVEL = 5'h0f;
   localparam logic [7:0] NMI_NUM = 8'h0f;
   localparam logic [7:0] SRC_NUM_BASE = 8'h10;
   localparam int EXT_SET0_SRC = 0;
   localparam int EXT_SET1_SRC = 32;
   localparam logic [11:0] OFF_LEVEL_END = 12'h0bc;
   localparam logic [11:0] OFF_HOLD = 12'h0c0;
   localparam logic [7:0] OFF_EXT_SET0 = 8'h10;
   localparam logic [7:0] OFF_EXT_SET1 = 8'h11;
   localparam logic [1:0] EXT_ENA = 2'h0;
   localparam logic [1:0] EXT_REQ = 2'h1;
   localparam logic [1:0] EXT_MODE = 2'h2;
   localparam logic [11:0] OFF_DELAY = 12'h120;
   localparam logic [11:0] OFF_STATUS = 12'h124;
   localparam int HOLD_CTRL_BIT = 7;
   localparam int DELAY_REQ_BIT = 0;
   localparam int DELAY_LVL_LSB = 8;
   localparam logic [4:0] LEVEL_RST = 5'h1f;
   localparam logic [4:0] HOLD_LVL_RST = 5'h1f;

   typedef enum logic [1:0] {
      PIC_DET_LOW = 2'h0,
      PIC_DET_HIGH = 2'h1,
      PIC_DET_RISE = 2'h2,
      PIC_DET_FALL = 2'h3
   } pic_det_mode_t;

   typedef struct packed {
      logic valid;
      logic [4:0] level;
      logic [7:0] num;
   } pic_winner_t;
endpackage : pic_pkg

// ---- pic_ext_chan.sv ----
`timescale 1ns/1ps
module pic_ext_chan
   import pic_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic pin,
   input wire logic enable,
   input wire pic_det_mode_t mode,
   input wire logic clr,
   output logic req
);
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else if (ce) begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         req <= 1'b0;
      end else if (ce) begin
         unique case (mode)
            PIC_DET_LOW: req <= enable & ~sync; // [R9] [R13]
            PIC_DET_HIGH: req <= enable & sync; // [R9] [R13]
            PIC_DET_RISE: begin
               // Set wins over a clear in the same cycle
               if (enable && sync && !prev) req <= 1'b1; // [R9] [R13]
               else if (clr) req <= 1'b0;
            end
            PIC_DET_FALL: begin
               if (enable && !sync && prev) req <= 1'b1; // [R9] [R13]
               else if (clr) req <= 1'b0;
            end
         endcase
      end
   end

   a_level_follow: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R13]
      (enable && mode == PIC_DET_HIGH) |=> req == $past(sync))
      else $error("level channel does not follow input");
   a_edge_held: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R13]
      (mode == PIC_DET_RISE && req && !clr) |=> req)
      else $error("edge request lost before clear");
endmodule : pic_ext_chan

// ---- pic_top.sv ----
`timescale 1ns/1ps
module pic_top
   import pic_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_n_pin,
   input wire logic [EXT_CH-1:0] external_irq_inputs,
   input wire logic [NUM_SRC-1:0] periph_irq,
   input wire logic cpu_stop_mode,
   output logic irq_valid,
   output logic [4:0] irq_level,
   output logic [7:0] irq_num,
   output logic wake_req,
   output logic hold_cancel_req
);
   logic [4:0] irq_level_register [NUM_SRC];
   logic hold_cancel_control_bit;
   logic [4:0] hold_cancel_level;
   logic [EXT_CH-1:0] ext_ena;
   logic [2*EXT_CH-1:0] ext_mode;
   logic [EXT_CH-1:0] ext_req;
   logic [EXT_CH-1:0] ext_clr;
   logic delay_req;
   logic [4:0] delay_lvl;
   logic nmi_meta;
   logic nmi_sync;
   logic nmi_active;
   logic [NUM_CAND-1:0] cand_req;
   logic [4:0] cand_lvl [NUM_CAND];
   pic_winner_t win;
   logic any_pend;
   logic acc;
   logic wr_done;
   logic [5:0] lvl_idx;
   logic lvl_hit;
   logic ext_hit;
   logic ext_set;
   logic [31:0] next_prdata;
   logic next_pslverr;

   // APB: setup, then one wait cycle, then ready
   assign acc = psel & penable & ~pready;
   assign wr_done = psel & penable & pready & pwrite;
   assign lvl_idx = paddr[7:2];
   assign lvl_hit = (paddr < OFF_LEVEL_END) && (paddr[1:0] == 2'h0);
   assign ext_hit = (paddr[11:4] == OFF_EXT_SET0 || paddr[11:4] == OFF_EXT_SET1)
      && (paddr[1:0] == 2'h0) && (paddr[3:2] != 2'h3);
   assign ext_set = paddr[4];

   // NMI pin is active low
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         nmi_meta <= 1'b1;
         nmi_sync <= 1'b1;
      end else if (ce) begin
         nmi_meta <= nmi_n_pin;
         nmi_sync <= nmi_meta;
      end
   end
   assign nmi_active = ~nmi_sync; // [R1]

   // Per-source level registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            irq_level_register[i] <= LEVEL_RST;
         end
      end else if (ce && wr_done && lvl_hit) begin
         irq_level_register[lvl_idx] <= pwdata[4:0]; // [R7]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hold_cancel_control_bit <= 1'b0;
         hold_cancel_level <= HOLD_LVL_RST;
      end else if (ce && wr_done && paddr == OFF_HOLD) begin
         hold_cancel_control_bit <= pwdata[HOLD_CTRL_BIT]; // [R8]
         hold_cancel_level <= pwdata[4:0]; // [R8]
      end
   end

   // Delayed interrupt source
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         delay_req <= 1'b0;
         delay_lvl <= LEVEL_RST;
      end else if (ce && wr_done && paddr == OFF_DELAY) begin
         delay_req <= pwdata[DELAY_REQ_BIT]; // [R11]
         delay_lvl <= pwdata[DELAY_LVL_LSB +: 5];
      end
   end

   // External channel configuration, two sets of eight
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext_ena <= '0;
         ext_mode <= '0;
      end else if (ce && wr_done && ext_hit) begin
         if (paddr[3:2] == EXT_ENA) begin
            ext_ena[ext_set*EXT_SET_CH +: EXT_SET_CH] <= pwdata[7:0]; // [R10]
         end
         if (paddr[3:2] == EXT_MODE) begin
            ext_mode[ext_set*2*EXT_SET_CH +: 2*EXT_SET_CH] <= pwdata[15:0]; // [R9]
         end
      end
   end

   // Writing one to a request bit clears it in the rising and falling modes
   always_comb begin
      ext_clr = '0;
      if (ce && wr_done && ext_hit && paddr[3:2] == EXT_REQ) begin
         ext_clr[ext_set*EXT_SET_CH +: EXT_SET_CH] = pwdata[7:0]; // [R13]
      end
   end

   for (genvar c = 0; c < EXT_CH; c++) begin : g_ext
      pic_ext_chan u_chan (
         .core_clk(core_clk),
         .nrst(nrst),
         .ce(ce),
         .pin(external_irq_inputs[c]),
         .enable(ext_ena[c]),
         .mode(pic_det_mode_t'(ext_mode[2*c +: 2])),
         .clr(ext_clr[c]),
         .req(ext_req[c])
      ); // [R10]
   end

   // Candidate list: peripherals, external sets folded in, delayed last
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         cand_req[i] = periph_irq[i]; // [R1]
         cand_lvl[i] = irq_level_register[i];
      end
      cand_req[EXT_SET0_SRC] = periph_irq[EXT_SET0_SRC]
         | (|(ext_req[7:0] & ext_ena[7:0]));
      cand_req[EXT_SET1_SRC] = periph_irq[EXT_SET1_SRC]
         | (|(ext_req[15:8] & ext_ena[15:8]));
      cand_req[NUM_SRC] = delay_req; // [R11]
      cand_lvl[NUM_SRC] = delay_lvl;
   end

   // Strict compare keeps the lower number on equal levels
   always_comb begin
      win.valid = 1'b0;
      win.level = LVL_OFF;
      win.num = 8'h00;
      for (int i = 0; i < NUM_CAND; i++) begin
         if (cand_req[i] && cand_lvl[i] < win.level) begin // [R2] [R12]
            win.valid = 1'b1;
            win.level = cand_lvl[i];
            win.num = SRC_NUM_BASE + 8'(i);
         end
      end
      if (nmi_active) begin // [R1] [R2]
         win.valid = 1'b1;
         win.level = NMI_LEVEL;
         win.num = NMI_NUM;
      end
   end
   assign any_pend = win.valid;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_valid <= 1'b0;
         irq_level <= LVL_OFF;
         irq_num <= 8'h00;
      end else if (ce) begin
         irq_valid <= win.valid;
         irq_level <= win.level; // [R3]
         irq_num <= win.num; // [R4]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wake_req <= 1'b0;
      end else if (ce) begin
         wake_req <= cpu_stop_mode & any_pend; // [R5]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hold_cancel_req <= 1'b0;
      end else if (ce) begin
         hold_cancel_req <= hold_cancel_control_bit & win.valid
            & (win.level <= hold_cancel_level); // [R6] [R8]
      end
   end

   // Read mux
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (lvl_hit) begin
         next_prdata[4:0] = irq_level_register[lvl_idx]; // [R7]
      end else if (paddr == OFF_HOLD) begin
         next_prdata[HOLD_CTRL_BIT] = hold_cancel_control_bit;
         next_prdata[4:0] = hold_cancel_level;
      end else if (ext_hit) begin
         unique case (paddr[3:2])
            EXT_ENA: next_prdata[7:0] = ext_ena[ext_set*EXT_SET_CH +: EXT_SET_CH];
            EXT_REQ: next_prdata[7:0] = ext_req[ext_set*EXT_SET_CH +: EXT_SET_CH];
            default: next_prdata[15:0] = ext_mode[ext_set*2*EXT_SET_CH +: 2*EXT_SET_CH];
         endcase
      end else if (paddr == OFF_DELAY) begin
         next_prdata[DELAY_REQ_BIT] = delay_req;
         next_prdata[DELAY_LVL_LSB +: 5] = delay_lvl;
      end else if (paddr == OFF_STATUS) begin
         next_prdata[7:0] = win.num;
         next_prdata[12:8] = win.level;
         next_prdata[16] = win.valid;
      end else begin
         next_pslverr = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= acc;
         pslverr <= acc & next_pslverr;
         if (acc && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   sequence s_delay_set;
      ce && wr_done && paddr == OFF_DELAY && pwdata[DELAY_REQ_BIT];
   endsequence
   sequence s_delay_clr;
      ce && wr_done && paddr == OFF_DELAY && !pwdata[DELAY_REQ_BIT];
   endsequence

   a_delay_raise: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
      s_delay_set |=> delay_req)
      else $error("delayed request not raised");
   a_delay_drop: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
      s_delay_clr |=> !delay_req ##1 (!ce || !irq_valid || irq_num != 8'h3f))
      else $error("delayed request not withdrawn");
   a_nmi_wins: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R1]
      nmi_active |=> irq_num == NMI_NUM && irq_level == NMI_LEVEL && irq_valid)
      else $error("NMI did not win");
   a_no_disabled: assert property (@(posedge core_clk) disable iff (!nrst) // [R12]
      irq_valid |-> irq_level != LVL_OFF)
      else $error("disabled level delivered");
   a_num_range: assert property (@(posedge core_clk) disable iff (!nrst) // [R4]
      irq_valid |-> irq_num >= NMI_NUM && irq_num <= 8'h3f)
      else $error("vector number out of range");
   a_wake: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R5]
      (cpu_stop_mode && (nmi_active || cand_req[0] && cand_lvl[0] != LVL_OFF))
      |=> wake_req)
      else $error("wake not raised");
   a_hold_cancel: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R6]
      (hold_cancel_control_bit && win.valid && win.level <= hold_cancel_level)
      |=> hold_cancel_req)
      else $error("hold cancel not requested");
   a_level_read: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R7]
      (acc && !pwrite && lvl_hit) |=> pready && prdata[31:5] == 27'h0 && !pslverr)
      else $error("level register read wrong");

   // Register writes land one edge after the ready cycle
   sequence s_level_wr;
      ce && wr_done && lvl_hit;
   endsequence
   sequence s_hold_wr;
      ce && wr_done && paddr == OFF_HOLD;
   endsequence
   sequence s_ext_mode_wr;
      ce && wr_done && ext_hit && paddr[3:2] == EXT_MODE;
   endsequence

   a_level_write: assert property (@(posedge core_clk) disable iff (!nrst) // [R7]
      s_level_wr |=> irq_level_register[$past(lvl_idx)] == $past(pwdata[4:0]))
      else $error("level register write lost");
   a_hold_write: assert property (@(posedge core_clk) disable iff (!nrst) // [R8]
      s_hold_wr |=> hold_cancel_control_bit == $past(pwdata[HOLD_CTRL_BIT])
      && hold_cancel_level == $past(pwdata[4:0]))
      else $error("hold cancel register write lost");
   a_ext_mode_write: assert property (@(posedge core_clk) disable iff (!nrst) // [R9] [R10]
      s_ext_mode_wr |=> ext_mode[$past(ext_set)*2*EXT_SET_CH +: 2*EXT_SET_CH]
      == $past(pwdata[15:0]))
      else $error("external mode write lost");
   a_delay_level: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
      s_delay_set |=> delay_lvl == $past(pwdata[DELAY_LVL_LSB +: 5]))
      else $error("delayed request level not stored");

   // Bus answer: one wait state, one-cycle ready, error on unmapped
   a_one_wait: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R7]
      acc |=> pready)
      else $error("ready not given after one wait state");
   a_ready_pulse: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R7]
      pready |=> !pready)
      else $error("ready stood longer than one cycle");
   a_unmapped: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R7]
      (acc && next_pslverr) |=> pready && pslverr)
      else $error("unmapped access not refused");
   a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R7]
      (acc && !pwrite && next_pslverr) |=> prdata == 32'h0000_0000)
      else $error("unmapped read returned data");
   a_status_read: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R4]
      (acc && !pwrite && paddr == OFF_STATUS) |=> prdata[16] == $past(win.valid)
      && prdata[12:8] == $past(win.level) && prdata[7:0] == $past(win.num))
      else $error("status read does not match winner");

   // Output stage follows the winner, freezes with the clock enable
   a_level_out: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R3] [R4]
      ce |=> irq_level == $past(win.level) && irq_num == $past(win.num))
      else $error("winner not presented");
   a_valid_out: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R1]
      ce |=> irq_valid == $past(win.valid))
      else $error("request valid not presented");
   a_ce_freeze: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
      !ce |=> $stable(irq_level) && $stable(irq_num) && $stable(irq_valid))
      else $error("outputs moved while clock enable low");
   a_wake_off: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R5]
      !cpu_stop_mode |=> !wake_req)
      else $error("wake raised outside stop mode");
   a_hold_off: assert property (@(posedge core_clk) disable iff (!nrst || !ce) // [R8]
      !hold_cancel_control_bit |=> !hold_cancel_req)
      else $error("hold cancel requested while disabled");

   // No pending request may beat the chosen winner while NMI is inactive
   for (genvar k = 0; k < NUM_CAND; k++) begin : g_arb_chk
      a_no_better: assert property (@(posedge core_clk) disable iff (!nrst) // [R2] [R12]
         (cand_req[k] && cand_lvl[k] != LVL_OFF && !nmi_active)
         |-> win.valid && (win.level < cand_lvl[k] || (win.level == cand_lvl[k]
         && win.num <= SRC_NUM_BASE + 8'(k))))
         else $error("a better request lost arbitration");
   end
endmodule : pic_top

// ---- pic_cpu_model.sv ----
`timescale 1ns/1ps
module pic_cpu_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic sleep_cmd,
   input wire logic wake_req,
   output logic cpu_stop_mode
);
   // Enter stop on command, leave it once a wake request shows
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_stop_mode <= 1'b0;
      end else if (sleep_cmd) begin
         cpu_stop_mode <= 1'b1;
      end else if (wake_req) begin
         cpu_stop_mode <= 1'b0;
      end
   end
endmodule : pic_cpu_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import pic_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic nmi_n_pin = 1'b1;
   logic [EXT_CH-1:0] ext = '0;
   logic [NUM_SRC-1:0] periph_irq = '0;
   logic cpu_stop_mode, sleep_cmd = 1'b0;
   logic irq_valid, wake_req, hold_cancel_req;
   logic [4:0] irq_level;
   logic [7:0] irq_num;
   logic [31:0] rq;
   logic re;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;

   always #50 core_clk = ~core_clk;

   pic_top pic_top_inst (.core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_n_pin(nmi_n_pin),
      .external_irq_inputs(ext), .periph_irq(periph_irq), .cpu_stop_mode(cpu_stop_mode),
      .irq_valid(irq_valid), .irq_level(irq_level), .irq_num(irq_num),
      .wake_req(wake_req), .hold_cancel_req(hold_cancel_req));

   pic_cpu_model pic_cpu_model_inst (.core_clk(core_clk), .nrst(nrst),
      .sleep_cmd(sleep_cmd), .wake_req(wake_req), .cpu_stop_mode(cpu_stop_mode));

   task complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] e, input logic er);
      apb(1'b0, a, 32'h0);
      chk(rq, e);
      chk(32'(re), 32'(er));
   endtask : rd

   task settle();
      repeat (6) @(posedge core_clk);
      #1;
   endtask : settle

   task irq(input logic v, input logic [4:0] l, input logic [7:0] n);
      settle();
      chk({18'h0, irq_valid, irq_level, irq_num}, {18'h0, v, l, n});
      @(posedge core_clk);
   endtask : irq

   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      rd(12'h000, 32'h1f, 1'b0);
      rd(12'h0c0, 32'h1f, 1'b0);
      rd(12'h200, 32'h0, 1'b1);
      wr(12'h00c, 32'hff);
      rd(12'h00c, 32'h1f, 1'b0);
      wr(12'h00c, 32'h4);
      wr(12'h014, 32'h4);
      periph_irq <= 47'h28;
      irq(1'b1, 5'h04, 8'h13);
      wr(12'h014, 32'h2);
      irq(1'b1, 5'h02, 8'h15);
      wr(12'h0c0, 32'h81);
      settle();
      chk(32'(hold_cancel_req), 32'h0);
      wr(12'h0c0, 32'h82);
      settle();
      chk(32'(hold_cancel_req), 32'h1);
      wr(12'h0c0, 32'h0);
      periph_irq <= 47'h80;
      sleep_cmd <= 1'b1;
      @(posedge core_clk);
      sleep_cmd <= 1'b0;
      irq(1'b0, 5'h1f, 8'h00);
      #1;
      chk({30'h0, cpu_stop_mode, wake_req}, 32'h2);
      @(posedge core_clk);
      periph_irq <= 47'h88;
      settle();
      chk(32'(cpu_stop_mode), 32'h0);
      @(posedge core_clk);
      nmi_n_pin <= 1'b0;
      irq(1'b1, 5'h0f, 8'h0f);
      nmi_n_pin <= 1'b1;
      periph_irq <= '0;
      wr(12'h080, 32'h1);
      wr(12'h118, 32'h2);
      wr(12'h110, 32'h1);
      ext[8] <= 1'b1;
      settle();
      @(posedge core_clk);
      ext[8] <= 1'b0;
      irq(1'b1, 5'h01, 8'h30);
      rd(12'h114, 32'h1, 1'b0);
      wr(12'h114, 32'h1);
      irq(1'b0, 5'h1f, 8'h00);
      wr(12'h118, 32'h3);
      ext[8] <= 1'b1;
      irq(1'b0, 5'h1f, 8'h00);
      ext[8] <= 1'b0;
      irq(1'b1, 5'h01, 8'h30);
      wr(12'h114, 32'h1);
      wr(12'h000, 32'h3);
      wr(12'h108, 32'h1);
      wr(12'h100, 32'h1);
      ext[0] <= 1'b1;
      irq(1'b1, 5'h03, 8'h10);
      ext[0] <= 1'b0;
      irq(1'b0, 5'h1f, 8'h00);
      wr(12'h108, 32'h0);
      irq(1'b1, 5'h03, 8'h10);
      wr(12'h100, 32'h0);
      wr(12'h120, 32'h301);
      irq(1'b1, 5'h03, 8'h3f);
      rd(12'h124, 32'h0001_033f, 1'b0);
      rd(12'h120, 32'h0000_0301, 1'b0);
      ce <= 1'b0;
      periph_irq <= 47'h1;
      settle();
      chk({24'h0, irq_num}, 32'h3f);
      @(posedge core_clk);
      ce <= 1'b1;
      irq(1'b1, 5'h03, 8'h10);
      periph_irq <= '0;
      wr(12'h120, 32'h0);
      irq(1'b0, 5'h1f, 8'h00);
      complete_run();
   end
endmodule : tb_top
